// *** rtl/system_tick_down_timer.sv ***
// Purpose: 24-bit periodic down-counting tick timer with its own exception
// Assumes: single 50 MHz clock; software is the only bus master
// Notes: divided tick source is a pulse from tick_divider
`timescale 1ns/100ps
`include "tick_timer_regs.svh"
// Contract
// - 24-bit down counter, request at zero
// - dedicated exception output, not shared line
// - clock select 1 system, 0 divided
// - divided tick from programmable main divider
// - reload zero never raises interrupt
// - current-value write clears count
// - read-only calibration, ten ms field
// - calibration_flag_a and no-reference from calibration setting
// - 0x3 enables with divided clock
// - 0x7 enables with system clock
// - readable wrap flag
// - no external pins used
module system_tick_down_timer #(
   parameter int CNT_W = `TT_CNT_W,
   parameter int DIV_W = `TT_DIV_W
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic clk_en,
   input wire tick_timer_pkg::bus_req_t bus,
   output logic [31:0] rdata,
   output logic tick_exception,
   output logic irq
);
   import tick_timer_pkg::*;

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   logic enable_q; // counter enable
   logic irq_en_q; // exception enable
   logic clksel_q; // 1 system clock, 0 divided tick
   logic wrap_q; // count flag
   logic [CNT_W-1:0] reload_q; // reload value
   logic [CNT_W-1:0] count_q; // current value
   calib_t calset_q; // system-level calibration setting
   logic [DIV_W-1:0] div_q; // tick clock divider setting
   logic [1:0] ists_q; // sticky: bit0 wrap, bit1 calibration written
   logic [1:0] imask_q; // mask, same layout
   tick_state_t state_q; // counter phase
   logic div_tick; // divided tick pulse
   logic tick_en; // tick for this cycle
   logic zero_event; // counter reaching zero this tick
   logic wr_ctrl, wr_reload, wr_cur, wr_calset, wr_div, wr_mask;
   logic rd_ctrl, rd_ists;

   // address match for one strobe
   function automatic logic hit(input logic stb, input logic [7:0] a,
                                input logic [7:0] off);
      hit = stb && (a == off);
   endfunction

   assign wr_ctrl = hit(bus.wr, bus.addr, `TT_OFF_CTRL);
   assign wr_reload = hit(bus.wr, bus.addr, `TT_OFF_RELOAD);
   assign wr_cur = hit(bus.wr, bus.addr, `TT_OFF_CURRENT);
   assign wr_calset = hit(bus.wr, bus.addr, `TT_OFF_CALSET);
   assign wr_div = hit(bus.wr, bus.addr, `TT_OFF_DIV);
   assign wr_mask = hit(bus.wr, bus.addr, `TT_OFF_IRQ_MASK);
   assign rd_ctrl = hit(bus.rd, bus.addr, `TT_OFF_CTRL);
   assign rd_ists = hit(bus.rd, bus.addr, `TT_OFF_IRQ_STATUS);

   // -----------------------------------------------------------------
   // tick source
   // -----------------------------------------------------------------
   tick_divider #(.DIV_W(DIV_W)) u_div (
      .clock(clock),
      .arst_n(arst_n),
      .clk_en(clk_en),
      .divide(div_q),
      .tick(div_tick)
   );

   // system clock ticks every cycle; divided source only on its pulse
   assign tick_en = clksel_q ? 1'b1 : div_tick;
   // one-to-zero step is the event; a zero reload suppresses it outright
   assign zero_event = enable_q && tick_en && (state_q == st_count) &&
                       (reload_q != '0) &&
                       (count_q == {{(CNT_W-1){1'b0}}, 1'b1});

   // -----------------------------------------------------------------
   // control register
   // -----------------------------------------------------------------
   // bit layout makes 0x3 divided and 0x7 system-clock operation
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         enable_q <= 1'b0;
         irq_en_q <= 1'b0;
         clksel_q <= 1'b0;
      end else if (clk_en && wr_ctrl) begin
         enable_q <= bus.wdata[`TT_BIT_ENABLE];
         irq_en_q <= bus.wdata[`TT_BIT_IRQ_EN];
         clksel_q <= bus.wdata[`TT_BIT_CLKSEL];
      end
   end

   // -----------------------------------------------------------------
   // configuration registers
   // -----------------------------------------------------------------
   // software is expected to load reload before enabling
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         reload_q <= '0;
         calset_q <= '0;
         div_q <= `TT_RST_DIV;
         imask_q <= '0;
      end else if (clk_en) begin
         if (wr_reload) begin
            reload_q <= bus.wdata[CNT_W-1:0];
         end
         if (wr_calset) begin
            calset_q.ten_ms <= bus.wdata[23:0];
            calset_q.calibration_flag_a <= bus.wdata[`TT_BIT_CALIBRATION_FLAG_A];
            calset_q.no_reference_flag <= bus.wdata[`TT_BIT_NO_REFERENCE_FLAG];
         end
         if (wr_div) begin
            div_q <= bus.wdata[DIV_W-1:0];
         end
         if (wr_mask) begin
            imask_q <= bus.wdata[1:0];
         end
      end
   end

   // -----------------------------------------------------------------
   // counter
   // -----------------------------------------------------------------
   // a cleared counter loads reload on its next tick, giving reload+1
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         count_q <= '0;
         state_q <= st_reload;
      end else if (clk_en) begin
         if (wr_cur) begin
            count_q <= '0;
            state_q <= st_reload;
         end else if (enable_q && tick_en) begin
            case (state_q)
               st_reload: begin
                  count_q <= reload_q;
                  state_q <= (reload_q == '0) ? st_idle : st_count;
               end
               st_count: begin
                  count_q <= count_q - 1'b1;
                  if (count_q == {{(CNT_W-1){1'b0}}, 1'b1}) begin
                     state_q <= st_reload;
                  end
               end
               st_idle: begin
                  // parked at zero: only a nonzero reload restarts
                  if (reload_q != '0) begin
                     count_q <= reload_q;
                     state_q <= st_count;
                  end
               end
               default: state_q <= st_reload;
            endcase
         end
      end
   end

   // -----------------------------------------------------------------
   // wrap flag
   // -----------------------------------------------------------------
   // set wins over the read or write that clears it
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         wrap_q <= 1'b0;
      end else if (clk_en) begin
         if (zero_event) begin
            wrap_q <= 1'b1;
         end else if (rd_ctrl || wr_cur) begin
            wrap_q <= 1'b0;
         end
      end
   end

   // -----------------------------------------------------------------
   // exception and interrupt status
   // -----------------------------------------------------------------
   // exception pulse is its own output, kept apart from the shared irq
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         tick_exception <= 1'b0;
      end else if (clk_en) begin
         tick_exception <= zero_event && irq_en_q;
      end
   end

   // sticky bits, cleared by reading; a fresh event beats the clear
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ists_q <= '0;
      end else if (clk_en) begin
         ists_q <= (rd_ists ? 2'b00 : ists_q) | {wr_calset, zero_event};
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         irq <= 1'b0;
      end else if (clk_en) begin
         irq <= |(ists_q & imask_q);
      end
   end

   // -----------------------------------------------------------------
   // read port
   // -----------------------------------------------------------------
   // unmapped addresses read zero; calibration register has no write
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rdata <= '0;
      end else if (clk_en) begin
         rdata <= '0;
         if (bus.rd) begin
            case (bus.addr)
               `TT_OFF_CTRL: begin
                  rdata[`TT_BIT_ENABLE] <= enable_q;
                  rdata[`TT_BIT_IRQ_EN] <= irq_en_q;
                  rdata[`TT_BIT_CLKSEL] <= clksel_q;
                  rdata[`TT_BIT_WRAP] <= wrap_q;
               end
               `TT_OFF_RELOAD: rdata[CNT_W-1:0] <= reload_q;
               `TT_OFF_CURRENT: rdata[CNT_W-1:0] <= count_q;
               `TT_OFF_CALIB: begin
                  rdata[23:0] <= calset_q.ten_ms;
                  rdata[`TT_BIT_CALIBRATION_FLAG_A] <= calset_q.calibration_flag_a;
                  rdata[`TT_BIT_NO_REFERENCE_FLAG] <= calset_q.no_reference_flag;
               end
               `TT_OFF_CALSET: begin
                  rdata[23:0] <= calset_q.ten_ms;
                  rdata[`TT_BIT_CALIBRATION_FLAG_A] <= calset_q.calibration_flag_a;
                  rdata[`TT_BIT_NO_REFERENCE_FLAG] <= calset_q.no_reference_flag;
               end
               `TT_OFF_DIV: rdata[DIV_W-1:0] <= div_q;
               `TT_OFF_IRQ_STATUS: rdata[1:0] <= ists_q;
               `TT_OFF_IRQ_MASK: rdata[1:0] <= imask_q;
               default: rdata <= '0;
            endcase
         end
      end
   end

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n || !clk_en);

   chk_exc_on_zero: assert property (
      zero_event && irq_en_q |=> tick_exception)
      else $error("exception missing at zero");
   chk_zero_reload_quiet: assert property (
      reload_q == '0 && $stable(reload_q) |=> !zero_event)
      else $error("zero reload raised event");
   chk_cur_clear: assert property (
      wr_cur |=> count_q == '0 && !wrap_q || $past(zero_event))
      else $error("current write did not clear");
   chk_wrap_set: assert property (
      zero_event |=> wrap_q && state_q == st_reload)
      else $error("wrap flag not set");
   chk_wrap_rdclr: assert property (
      rd_ctrl && !zero_event && !wr_cur |=> !wrap_q)
      else $error("status read left flag");
   chk_calib_ro: assert property (
      hit(bus.wr, bus.addr, `TT_OFF_CALIB) |=> $stable(calset_q))
      else $error("calibration changed by write");
   chk_sysclk_dec: assert property (
      enable_q && clksel_q && state_q == st_count && !wr_cur &&
      count_q > 24'h1 |=> count_q == $past(count_q) - 1'b1)
      else $error("system clock did not decrement");
   chk_div_hold: assert property (
      enable_q && !clksel_q && !div_tick && !wr_cur |=> $stable(count_q))
      else $error("counted without divided tick");
   chk_ctrl_write: assert property (
      wr_ctrl && bus.wdata[2:0] == 3'h7 |=> enable_q && irq_en_q && clksel_q)
      else $error("0x7 not decoded");
   chk_irq_level: assert property (
      |(ists_q & imask_q) |=> irq)
      else $error("irq not raised");

   cov_wrap: cover property (zero_event ##1 rd_ctrl);
   cov_divided: cover property (enable_q && !clksel_q && zero_event);
   cov_clear_race: cover property (zero_event && rd_ctrl);
endmodule

// *** include/tick_timer_regs.svh ***
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: word-aligned register file, 32-bit data
// Notes: definitions only
`ifndef TICK_TIMER_REGS_SVH
`define TICK_TIMER_REGS_SVH
`define TT_OFF_CTRL 8'h00
`define TT_OFF_RELOAD 8'h04
`define TT_OFF_CURRENT 8'h08
`define TT_OFF_CALIB 8'h0c
`define TT_OFF_CALSET 8'h10
`define TT_OFF_DIV 8'h14
`define TT_OFF_IRQ_STATUS 8'h18
`define TT_OFF_IRQ_MASK 8'h1c
`define TT_BIT_ENABLE 0
`define TT_BIT_IRQ_EN 1
`define TT_BIT_CLKSEL 2
`define TT_BIT_WRAP 16
`define TT_BIT_CALIBRATION_FLAG_A 30
`define TT_BIT_NO_REFERENCE_FLAG 31
`define TT_CNT_W 24
`define TT_DIV_W 8
`define TT_RST_DIV 8'h00
`define TT_TEN_MS_US 10000
`define TT_CLK_MHZ 50
`define TT_TEN_MS_CYCLES (`TT_TEN_MS_US * `TT_CLK_MHZ)
`endif

// *** include/tick_timer_pkg.sv ***
// Purpose: types shared by the tick timer files
// Assumes: nothing
// Notes: bus request travels as one packed struct
package tick_timer_pkg;
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } bus_req_t;
   typedef struct packed {
      logic no_reference_flag;
      logic calibration_flag_a;
      logic [23:0] ten_ms;
   } calib_t;
   typedef enum logic [1:0] {st_idle, st_count, st_reload} tick_state_t;
endpackage

// *** rtl/tick_divider.sv ***
// Purpose: programmable divider making the divided tick clock enable
// Assumes: setting n divides by n+1
// Notes: output is a one-cycle tick pulse, not a real clock
`timescale 1ns/100ps
`include "tick_timer_regs.svh"
module tick_divider #(
   parameter int DIV_W = `TT_DIV_W
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic clk_en,
   input wire logic [DIV_W-1:0] divide,
   output logic tick
);
   logic [DIV_W-1:0] cnt_q; // cycles since last tick

   // -----------------------------------------------------------------
   // divider counter
   // -----------------------------------------------------------------
   // a pulse rather than a gated clock keeps the block on one clock
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q <= '0;
         tick <= 1'b0;
      end else if (clk_en) begin
         if (cnt_q >= divide) begin
            cnt_q <= '0;
            tick <= 1'b1;
         end else begin
            cnt_q <= cnt_q + 1'b1;
            tick <= 1'b0;
         end
      end
   end
endmodule

// *** testbench/system_tick_down_timer_bench.sv ***
// Purpose: self-checking bench for the system tick down timer
// Assumes: one 50 MHz clock, bench is the only bus master
// Notes: periods are counted on falling edges, where outputs are settled
`timescale 1ns/100ps
`include "tick_timer_regs.svh"
module system_tick_down_timer_bench;
   import tick_timer_pkg::*;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic clock; // 20 ns bench clock
   logic arst_n; // asynchronous reset, active low
   logic clk_en; // held high except where the freeze test drives it low
   bus_req_t bus_req; // register request toward the timer
   logic [31:0] rdata; // read data, valid one cycle
   logic tick_exception; // dedicated exception pulse
   logic irq; // level interrupt from status and mask
   int fail_count; // mismatches seen
   int checked; // comparisons made
   int cycles; // timeout counter
   int n; // measured cycles or pulses
   system_tick_down_timer u_system_tick_down_timer (
      .clock(clock),
      .arst_n(arst_n),
      .clk_en(clk_en),
      .bus(bus_req),
      .rdata(rdata),
      .tick_exception(tick_exception),
      .irq(irq)
   );
   // clock: inverted every half period
   initial clock = 1'b0;
   always #10 clock = ~clock;
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   // one-cycle write strobe, dropped on the edge that takes it
   task automatic bus_write(input logic [7:0] addr, input logic [31:0] data);
      @(posedge clock);
      bus_req <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
      @(posedge clock);
      bus_req.wr <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic bus_read(input logic [7:0] addr, output logic [31:0] data);
      @(posedge clock);
      bus_req <= '{addr: addr, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
      @(posedge clock);
      bus_req.rd <= 1'b0;
      @(negedge clock);
      data = rdata;
   endtask
   task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check_cycles(input int got, input int exp);
      checked++;
      if (got != exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check_read(input logic [7:0] addr, input logic [31:0] exp);
      logic [31:0] v;
      bus_read(addr, v);
      check_reg(v, exp);
   endtask
   // cycles until the next exception pulse, bounded so a dead timer fails
   task automatic wait_exc(output int cnt);
      cnt = 0;
      do begin
         @(negedge clock);
         cnt++;
      end while (tick_exception !== 1'b1 && cnt < 2000);
   endtask
   // number of exception pulses seen in a window of len cycles
   task automatic count_exc(input int len, output int hits);
      hits = 0;
      repeat (len) begin
         @(negedge clock);
         if (tick_exception === 1'b1) begin
            hits++;
         end
      end
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // hang guard: whole sequence needs well under a thousand cycles
   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         final_report();
      end
   end
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      arst_n = 1'b0;
      clk_en = 1'b1;
      bus_req = '0;
      fail_count = 0;
      checked = 0;
      cycles = 0;
      repeat (10) @(posedge clock);
      arst_n <= 1'b1;
      // reset state and an unmapped address
      check_read(`TT_OFF_CTRL, 32'h0000_0000);
      check_read(`TT_OFF_CALIB, 32'h0000_0000);
      check_read(8'h20, 32'h0000_0000);
      // calibration mirrors the setting; direct writes are dropped
      bus_write(`TT_OFF_CALSET, 32'hc012_3456);
      check_read(`TT_OFF_CALIB, 32'hc012_3456);
      bus_write(`TT_OFF_CALIB, 32'h0000_0000);
      check_read(`TT_OFF_CALIB, 32'hc012_3456);
      bus_write(`TT_OFF_CALSET, 32'h4000_00aa);
      check_read(`TT_OFF_CALIB, 32'h4000_00aa);
      check_read(`TT_OFF_IRQ_STATUS, 32'h0000_0002);
      check_read(`TT_OFF_IRQ_STATUS, 32'h0000_0000);
      // system clock source: period is reload plus one; the first pulse
      // also waits one cycle for the enable or clear to land
      bus_write(`TT_OFF_RELOAD, 32'h0000_0028);
      check_read(`TT_OFF_RELOAD, 32'h0000_0028);
      bus_write(`TT_OFF_CTRL, 32'h0000_0007);
      wait_exc(n);
      check_cycles(n, 42);
      wait_exc(n);
      check_cycles(n, 41);
      check_read(`TT_OFF_CTRL, 32'h0001_0007);
      check_read(`TT_OFF_CTRL, 32'h0000_0007);
      check_reg({31'h0, irq}, 32'h0000_0000);
      // unmasked wrap event raises the level, status read drops it
      bus_write(`TT_OFF_IRQ_MASK, 32'h0000_0001);
      wait_exc(n);
      repeat (2) @(negedge clock);
      check_reg({31'h0, irq}, 32'h0000_0001);
      bus_write(`TT_OFF_CTRL, 32'h0000_0000);
      check_read(`TT_OFF_IRQ_STATUS, 32'h0000_0001);
      repeat (2) @(negedge clock);
      check_reg({31'h0, irq}, 32'h0000_0000);
      // current-value write clears the flag and restarts from reload
      bus_write(`TT_OFF_CTRL, 32'h0000_0007);
      wait_exc(n);
      bus_write(`TT_OFF_CURRENT, 32'h00ab_cdef);
      check_read(`TT_OFF_CTRL, 32'h0000_0007);
      bus_write(`TT_OFF_CURRENT, 32'h0000_0000);
      wait_exc(n);
      check_cycles(n, 42);
      // zero reload parks the counter: no pulses at all
      bus_write(`TT_OFF_RELOAD, 32'h0000_0000);
      bus_write(`TT_OFF_CURRENT, 32'h0000_0000);
      count_exc(200, n);
      check_cycles(n, 0);
      check_read(`TT_OFF_CURRENT, 32'h0000_0000);
      bus_write(`TT_OFF_RELOAD, 32'h0000_0002);
      wait_exc(n);
      wait_exc(n);
      check_cycles(n, 3);
      // divided source: each tick is divide setting plus one cycles
      for (int d = 0; d < 4; d++) begin
         bus_write(`TT_OFF_DIV, d);
         check_read(`TT_OFF_DIV, d);
         bus_write(`TT_OFF_CTRL, 32'h0000_0003);
         wait_exc(n);
         wait_exc(n);
         check_cycles(n, 3 * (d + 1));
      end
      // a low clock enable freezes the count and holds the pulse low
      @(posedge clock);
      clk_en <= 1'b0;
      count_exc(50, n);
      check_cycles(n, 0);
      @(posedge clock);
      clk_en <= 1'b1;
      wait_exc(n);
      wait_exc(n);
      check_cycles(n, 12);
      final_report();
   end
endmodule
